// ### tvfs_supervisor.v
// Temperature and input over-voltage limit commands with fault response control.
//
// How it works
// - Response 00 ignores the fault entirely.
// - Response 01 rides through delay, then retries.
// - Response 10 disables at once, then retries.
// - Response 11 stays off while fault persists.
// - Retry count zero latches off until cleared.
// - Delay code n means 2^n time units.
// - Unit length comes from outside configuration register.
// - Over-temperature warning when temperature exceeds limit.
// - Under-temperature warning when temperature below limit.
// - Under-temperature fault invokes its response byte.
// - Input over-voltage fault invokes its response byte.
// - Input over-voltage warning when input exceeds limit.
// - Fixed units: 10 ms ride, 8.2 ms retry.
`timescale 1ns/1ps
`include "tvfs_defs.vh"

module tvfs_supervisor #(
  parameter [23:0] RIDE_UNIT_CYC  = `TVFS_RIDE_UNIT_CYC,
  parameter [23:0] RETRY_UNIT_CYC = `TVFS_RETRY_UNIT_CYC,
  parameter [1:0]  FIXED_UNITS    = 2'h0
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rstn,
  // Command access from the bus engine, one command per strobe.
  input  wire [7:0]  cmd_code,
  input  wire        cmd_wr,
  input  wire        cmd_rd,
  input  wire [15:0] cmd_wdata,
  output reg  [15:0] cmd_rdata,
  output reg         cmd_ack,
  output reg         cmd_unsupported,
  // Telemetry in linear format and shared delay unit.
  input  wire [15:0] temp_reading,
  input  wire [15:0] vin_reading,
  input  wire [23:0] delay_unit_cyc,
  input  wire        clear_faults,
  // Status.
  output reg         ot_warning,
  output reg         ut_warning,
  output reg         ut_fault,
  output reg         vin_ov_warning,
  output reg         vin_ov_fault,
  output reg         ut_latched_off,
  output reg         vin_ov_latched_off,
  output reg         output_disable
);

  reg  [15:0] over_temp_warning_limit;
  reg  [15:0] under_temp_warning_limit;
  reg  [15:0] under_temp_fault_limit;
  reg  [7:0]  under_temp_fault_action;
  reg  [15:0] input_overvoltage_fault_limit;
  reg  [7:0]  input_overvoltage_fault_action;
  reg  [15:0] input_overvoltage_warning_limit;

  // Linear word to signed fixed point with 16 fraction bits.
  function signed [47:0] lin_fix;
    input [15:0] w;
    reg signed [47:0] m;
    reg [4:0] ne;
    begin
      m  = {{21{w[`TVFS_LIN_MANT_HI]}}, w[`TVFS_LIN_MANT_HI:0], 16'h0000};
      ne = 5'h00 - w[`TVFS_LIN_EXP_HI:`TVFS_LIN_EXP_LO];
      if (w[`TVFS_LIN_EXP_HI])
        lin_fix = m >>> ne;
      else
        lin_fix = m <<< w[`TVFS_LIN_EXP_HI:`TVFS_LIN_EXP_LO];
    end
  endfunction

  wire signed [47:0] temp_fx  = lin_fix(temp_reading);
  wire signed [47:0] vin_fx   = lin_fix(vin_reading);
  wire signed [47:0] otw_fx   = lin_fix(over_temp_warning_limit);
  wire signed [47:0] utw_fx   = lin_fix(under_temp_warning_limit);
  wire signed [47:0] utf_fx   = lin_fix(under_temp_fault_limit);
  wire signed [47:0] vovf_fx  = lin_fix(input_overvoltage_fault_limit);
  wire signed [47:0] vovw_fx  = lin_fix(input_overvoltage_warning_limit);

  // Register access.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      over_temp_warning_limit         <= `TVFS_RST_OT_WARN;
      under_temp_warning_limit        <= `TVFS_RST_UT_WARN;
      under_temp_fault_limit          <= `TVFS_RST_UT_FAULT;
      under_temp_fault_action         <= `TVFS_RST_ACTION;
      input_overvoltage_fault_limit   <= `TVFS_RST_VOV_FAULT;
      input_overvoltage_fault_action  <= `TVFS_RST_ACTION;
      input_overvoltage_warning_limit <= `TVFS_RST_VOV_WARN;
      cmd_rdata       <= 16'h0000;
      cmd_ack         <= 1'b0;
      cmd_unsupported <= 1'b0;
    end else begin
      cmd_ack         <= cmd_wr | cmd_rd;
      cmd_unsupported <= 1'b0;
      if (cmd_wr) begin
        case (cmd_code)
          `TVFS_CMD_OT_WARN:    over_temp_warning_limit <= cmd_wdata;
          `TVFS_CMD_UT_WARN:    under_temp_warning_limit <= cmd_wdata;
          `TVFS_CMD_UT_FAULT:   under_temp_fault_limit <= cmd_wdata;
          `TVFS_CMD_UT_ACTION:  under_temp_fault_action <= cmd_wdata[7:0];
          `TVFS_CMD_VOV_FAULT:  input_overvoltage_fault_limit <= cmd_wdata;
          `TVFS_CMD_VOV_ACTION: input_overvoltage_fault_action <= cmd_wdata[7:0];
          `TVFS_CMD_VOV_WARN:   input_overvoltage_warning_limit <= cmd_wdata;
          default:              cmd_unsupported <= 1'b1;
        endcase
      end else if (cmd_rd) begin
        case (cmd_code)
          `TVFS_CMD_OT_WARN:    cmd_rdata <= over_temp_warning_limit;
          `TVFS_CMD_UT_WARN:    cmd_rdata <= under_temp_warning_limit;
          `TVFS_CMD_UT_FAULT:   cmd_rdata <= under_temp_fault_limit;
          `TVFS_CMD_UT_ACTION:  cmd_rdata <= {8'h00, under_temp_fault_action};
          `TVFS_CMD_VOV_FAULT:  cmd_rdata <= input_overvoltage_fault_limit;
          `TVFS_CMD_VOV_ACTION: cmd_rdata <= {8'h00, input_overvoltage_fault_action};
          `TVFS_CMD_VOV_WARN:   cmd_rdata <= input_overvoltage_warning_limit;
          default: begin
            cmd_rdata       <= 16'h0000;
            cmd_unsupported <= 1'b1;
          end
        endcase
      end
    end
  end

  // Limit comparisons, registered.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ot_warning     <= 1'b0;
      ut_warning     <= 1'b0;
      ut_fault       <= 1'b0;
      vin_ov_warning <= 1'b0;
      vin_ov_fault   <= 1'b0;
    end else begin
      ot_warning     <= temp_fx > otw_fx;
      ut_warning     <= temp_fx < utw_fx;
      ut_fault       <= temp_fx < utf_fx;
      vin_ov_warning <= vin_fx > vovw_fx;
      vin_ov_fault   <= vin_fx > vovf_fx;
    end
  end

  // One response engine per fault: channel 0 under-temperature, channel 1 input over-voltage.
  wire [1:0]  ch_fault  = {vin_ov_fault, ut_fault};
  wire [15:0] ch_action = {input_overvoltage_fault_action, under_temp_fault_action};
  wire [1:0]  ch_off;
  wire [1:0]  ch_latched;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      tvfs_fault_engine u_engine (
        .clk        (clk),
        .rstn       (rstn),
        .fault      (ch_fault[g]),
        .action     (ch_action[8*g+7:8*g]),
        .ride_unit  (FIXED_UNITS[g] ? RIDE_UNIT_CYC : delay_unit_cyc),
        .retry_unit (FIXED_UNITS[g] ? RETRY_UNIT_CYC : delay_unit_cyc),
        .clear_req  (clear_faults),
        .out_off    (ch_off[g]),
        .latched    (ch_latched[g])
      );
    end
  endgenerate

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_disable     <= 1'b0;
      ut_latched_off     <= 1'b0;
      vin_ov_latched_off <= 1'b0;
    end else begin
      output_disable     <= |ch_off;
      ut_latched_off     <= ch_latched[0];
      vin_ov_latched_off <= ch_latched[1];
    end
  end

endmodule // tvfs_supervisor

// ### tvfs_defs.vh
// Command codes, field positions, reset values and timing counts of the supervisor.
`ifndef TVFS_DEFS_VH
`define TVFS_DEFS_VH

`define TVFS_CMD_OT_WARN      8'h51
`define TVFS_CMD_UT_WARN      8'h52
`define TVFS_CMD_UT_FAULT     8'h53
`define TVFS_CMD_UT_ACTION    8'h54
`define TVFS_CMD_VOV_FAULT    8'h55
`define TVFS_CMD_VOV_ACTION   8'h56
`define TVFS_CMD_VOV_WARN     8'h57

`define TVFS_RESP_HI          7
`define TVFS_RESP_LO          6
`define TVFS_RETRY_HI         5
`define TVFS_RETRY_LO         3
`define TVFS_DELAY_HI         2
`define TVFS_DELAY_LO         0

`define TVFS_RESP_IGNORE      2'h0
`define TVFS_RESP_RIDE        2'h1
`define TVFS_RESP_RETRY       2'h2
`define TVFS_RESP_HOLD        2'h3

`define TVFS_LIN_EXP_HI       15
`define TVFS_LIN_EXP_LO       11
`define TVFS_LIN_MANT_HI      10

`define TVFS_RST_OT_WARN      16'h007D
`define TVFS_RST_UT_WARN      16'h07E2
`define TVFS_RST_UT_FAULT     16'h07D8
`define TVFS_RST_VOV_FAULT    16'h0041
`define TVFS_RST_VOV_WARN     16'h003E
`define TVFS_RST_ACTION       8'hC0

// Fixed unit lengths in cycles of the 25 MHz clock: 10 ms ride-through and 8.2 ms between restarts.
`define TVFS_RIDE_UNIT_CYC    24'h03D090
`define TVFS_RETRY_UNIT_CYC   24'h0320C8

`endif

// ### tvfs_fault_engine.v
// Response sequencer for one fault source: ride-through, retries, hold and latch-off.
`timescale 1ns/1ps
`include "tvfs_defs.vh"

module tvfs_fault_engine (
  // Clock and reset.
  input  wire        clk,
  input  wire        rstn,
  // Fault source and programming.
  input  wire        fault,
  input  wire [7:0]  action,
  input  wire [23:0] ride_unit,
  input  wire [23:0] retry_unit,
  input  wire        clear_req,
  // Result.
  output reg         out_off,
  output reg         latched
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RIDE  = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_LATCH = 3'h3;
  localparam [2:0] ST_HOLD  = 3'h4;

  reg  [2:0]  state;
  reg  [31:0] cnt;
  reg  [2:0]  retries_left;

  wire [1:0]  resp  = action[`TVFS_RESP_HI:`TVFS_RESP_LO];
  wire [2:0]  retry = action[`TVFS_RETRY_HI:`TVFS_RETRY_LO];
  wire [2:0]  dcode = action[`TVFS_DELAY_HI:`TVFS_DELAY_LO];
  // Delay is 2^code units; a zero unit length is stretched to one cycle.
  wire [31:0] ride_len  = {8'h00, ride_unit} << dcode;
  wire [31:0] retry_len = {8'h00, retry_unit} << dcode;
  wire [31:0] ride_ld   = (ride_len == 32'h0) ? 32'h1 : ride_len;
  wire [31:0] retry_ld  = (retry_len == 32'h0) ? 32'h1 : retry_len;
  wire        expired   = (cnt == 32'h1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state        <= ST_IDLE;
      cnt          <= 32'h0;
      retries_left <= 3'h0;
      out_off      <= 1'b0;
      latched      <= 1'b0;
    end else begin
      if (cnt != 32'h0)
        cnt <= cnt - 32'h1;
      case (state)
        ST_IDLE: begin
          out_off <= 1'b0;
          latched <= 1'b0;
          retries_left <= retry;
          if (fault) begin
            case (resp)
              `TVFS_RESP_IGNORE: state <= ST_IDLE;
              `TVFS_RESP_RIDE: begin
                state <= ST_RIDE;
                cnt   <= ride_ld;
              end
              `TVFS_RESP_RETRY: begin
                out_off <= 1'b1;
                if (retry == 3'h0) begin
                  state   <= ST_LATCH;
                  latched <= 1'b1;
                end else begin
                  state <= ST_WAIT;
                  cnt   <= retry_ld;
                end
              end
              default: begin
                state   <= ST_HOLD;
                out_off <= 1'b1;
              end
            endcase
          end
        end
        ST_RIDE: begin
          if (!fault) begin
            state <= ST_IDLE;
            cnt   <= 32'h0;
          end else if (expired) begin
            out_off <= 1'b1;
            if (retries_left == 3'h0) begin
              state   <= ST_LATCH;
              latched <= 1'b1;
            end else begin
              state <= ST_WAIT;
              cnt   <= retry_ld;
            end
          end
        end
        ST_WAIT: begin
          // Each expiry is one restart attempt; a fault still present uses it up.
          if (expired) begin
            if (!fault) begin
              state   <= ST_IDLE;
              out_off <= 1'b0;
            end else if (retries_left == 3'h1) begin
              state   <= ST_LATCH;
              latched <= 1'b1;
            end else begin
              retries_left <= retries_left - 3'h1;
              cnt          <= retry_ld;
            end
          end
        end
        ST_LATCH: begin
          out_off <= 1'b1;
          if (clear_req && !fault) begin
            state   <= ST_IDLE;
            out_off <= 1'b0;
            latched <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (!fault) begin
            state   <= ST_IDLE;
            out_off <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // tvfs_fault_engine

// ### tvfs_checker.sv
// Port-level checks for the temperature and input over-voltage supervisor.
`timescale 1ns/1ps
module tvfs_checker (
  // Clock and reset.
  input wire        clk,
  input wire        rstn,
  // Command port.
  input wire [7:0]  cmd_code,
  input wire        cmd_wr,
  input wire        cmd_rd,
  input wire [15:0] cmd_rdata,
  input wire        cmd_ack,
  input wire        cmd_unsupported,
  // Fault status.
  input wire        clear_faults,
  input wire        ut_fault,
  input wire        vin_ov_fault,
  input wire        ut_latched_off,
  input wire        output_disable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire req     = cmd_wr | cmd_rd;
  wire bad     = (cmd_code < 8'h51) || (cmd_code > 8'h57);
  wire any_flt = ut_fault | vin_ov_fault;
  sequence bad_rd_s; cmd_rd && !cmd_wr && bad; endsequence
  // A clear takes two edges to reach the latched flag, so the previous cycle must be clear-free too.
  sequence held_s; ut_latched_off && !clear_faults && !$past(clear_faults); endsequence
  ack_follow_a: assert property (req |=> cmd_ack) else $error("ack missing after strobe");
  ack_quiet_a: assert property (!req |=> !cmd_ack) else $error("ack without strobe");
  unsup_flag_a: assert property (req && bad |=> cmd_unsupported && cmd_ack) else $error("unknown code not flagged");
  sup_flag_a: assert property (req && !bad |=> !cmd_unsupported) else $error("known code flagged");
  bad_read_a: assert property (bad_rd_s |=> cmd_rdata == 16'h0000) else $error("unknown read not zero");
  rdata_hold_a: assert property (!cmd_rd |=> $stable(cmd_rdata)) else $error("read data moved");
  off_cause_a: assert property ($rose(output_disable) |-> $past(any_flt, 2))
    else $error("output off without fault");
  latch_off_a: assert property (ut_latched_off |-> ##[0:2] output_disable)
    else $error("latched channel not off");
  latch_hold_a: assert property (held_s |=> ut_latched_off)
    else $error("latch released without clear");
endmodule // tvfs_checker
bind tvfs_supervisor tvfs_checker u_tvfs_checker (.*);

// ### tvfs_host.sv
// Command-port host that issues single read and write accesses.
`timescale 1ns/1ps
module tvfs_host (
  // Clock.
  input  wire        clk,
  // Command port.
  output reg  [7:0]  cmd_code,
  output reg         cmd_wr,
  output reg         cmd_rd,
  output reg  [15:0] cmd_wdata,
  input  wire [15:0] cmd_rdata,
  input  wire        cmd_ack
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    cmd_wdata = 16'h0000;
  end
  // One strobe cycle; the answer is taken 1 ns after the edge that samples the strobe.
  task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] q, output a);
    begin
      @(posedge clk);
      #1;
      cmd_code = c;
      cmd_wdata = d;
      cmd_wr = w;
      cmd_rd = !w;
      @(posedge clk);
      #1;
      q = cmd_rdata;
      a = cmd_ack;
      cmd_wr = 1'h0;
      cmd_rd = 1'h0;
      // Released lines show no stale value.
      cmd_code = ~c;
      cmd_wdata = ~d;
    end
  endtask
endmodule // tvfs_host

// ### test_tvfs_supervisor.sv
// Self-checking bench for the supervisor command set and fault responses.
`timescale 1ns/1ps
`include "tvfs_defs.vh"
module test_tvfs_supervisor;
  reg         clk;
  reg         rstn;
  reg  [15:0] temp_reading;
  reg  [15:0] vin_reading;
  reg  [23:0] delay_unit_cyc;
  reg         clear_faults;
  wire [7:0]  cmd_code;
  wire        cmd_wr;
  wire        cmd_rd;
  wire [15:0] cmd_wdata;
  wire [15:0] cmd_rdata;
  wire        cmd_ack;
  wire        cmd_unsupported;
  wire [7:0]  st;
  integer     err_total;
  integer     tests_run;
  integer     i;
  reg  [15:0] q;
  reg         a;
  reg  [15:0] v;
  reg  [15:0] rst_tab [0:6];
  tvfs_supervisor #(.RIDE_UNIT_CYC(24'h00000A), .RETRY_UNIT_CYC(24'h000008), .FIXED_UNITS(2'h2)) u_tvfs_supervisor (
    .clk(clk), .rstn(rstn), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_unsupported(cmd_unsupported), .temp_reading(temp_reading),
    .vin_reading(vin_reading), .delay_unit_cyc(delay_unit_cyc), .clear_faults(clear_faults), .ot_warning(st[0]),
    .ut_warning(st[1]), .ut_fault(st[2]), .vin_ov_warning(st[3]), .vin_ov_fault(st[4]), .ut_latched_off(st[5]),
    .vin_ov_latched_off(st[6]), .output_disable(st[7]));
  tvfs_host u_tvfs_host (.clk(clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack));
  task chk(input [8*8:1] nm, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // The output must keep its old level for lo cycles and reach exp by cycle hi.
  task off_win(input exp, input integer lo, input integer hi);
    integer n;
    begin
      n = 0;
      while (st[7] !== exp && n < hi) begin
        cyc(1);
        n = n + 1;
      end
      chk("off_win", 16'h0001, (n >= lo) && (st[7] === exp));
    end
  endtask
  task ut_run(input [7:0] act);
    begin
      temp_reading = 16'h0019;
      u_tvfs_host.xfer(1'h1, `TVFS_CMD_UT_ACTION, {8'h00, act}, q, a);
      clear_faults = 1'h1;
      cyc(4);
      clear_faults = 1'h0;
      temp_reading = 16'h07D7;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    test_done;
  end
  initial begin
    err_total = 0;
    tests_run = 0;
    rstn = 1'h0;
    temp_reading = 16'h0019;
    vin_reading = 16'h0030;
    delay_unit_cyc = 24'h000004;
    clear_faults = 1'h0;
    rst_tab[0] = `TVFS_RST_OT_WARN;
    rst_tab[1] = `TVFS_RST_UT_WARN;
    rst_tab[2] = `TVFS_RST_UT_FAULT;
    rst_tab[3] = {8'h00, `TVFS_RST_ACTION};
    rst_tab[4] = `TVFS_RST_VOV_FAULT;
    rst_tab[5] = {8'h00, `TVFS_RST_ACTION};
    rst_tab[6] = `TVFS_RST_VOV_WARN;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'h1;
    for (i = 0; i < 7; i = i + 1) begin
      v = 16'hA5C3 ^ i[15:0];
      u_tvfs_host.xfer(1'h0, 8'h51 + i[7:0], 16'h0000, q, a);
      chk("reset", rst_tab[i], q);
      chk("sup_f", 16'h0002, {14'h0000, a, cmd_unsupported});
      u_tvfs_host.xfer(1'h1, 8'h51 + i[7:0], v, q, a);
      u_tvfs_host.xfer(1'h0, 8'h51 + i[7:0], 16'h0000, q, a);
      chk("rdback", (i == 3 || i == 5) ? {8'h00, v[7:0]} : v, q);
      u_tvfs_host.xfer(1'h1, 8'h51 + i[7:0], rst_tab[i], q, a);
    end
    u_tvfs_host.xfer(1'h0, 8'h58, 16'h0000, q, a);
    chk("unsup_rd", 16'h0000, q);
    chk("unsup_f", 16'h0003, {14'h0000, a, cmd_unsupported});
    u_tvfs_host.xfer(1'h1, 8'h50, 16'hFFFF, q, a);
    chk("unsup_w", 16'h0003, {14'h0000, a, cmd_unsupported});
    $display("registers done");
    temp_reading = 16'h007E;
    cyc(2);
    chk("ot_warn", 16'h0001, st[0]);
    u_tvfs_host.xfer(1'h1, `TVFS_CMD_OT_WARN, 16'h083C, q, a);
    temp_reading = 16'h0077;
    cyc(2);
    chk("lin_lo", 16'h0000, st[0]);
    temp_reading = 16'h0079;
    cyc(2);
    chk("lin_hi", 16'h0001, st[0]);
    temp_reading = 16'h07DD;
    vin_reading = 16'h003F;
    cyc(2);
    chk("ut_warn", 16'h0001, st[2:1]);
    chk("vov_warn", 16'h0001, {st[4], st[3]});
    $display("warnings done");
    ut_run(8'h00);
    cyc(30);
    chk("ignore", 16'h0000, st[7:5]);
    chk("ut_flt", 16'h0001, st[2]);
    ut_run(8'hC0);
    off_win(1'h1, 3, 5);
    temp_reading = 16'h0019;
    off_win(1'h0, 1, 6);
    ut_run(8'h80);
    off_win(1'h1, 3, 5);
    temp_reading = 16'h0019;
    cyc(6);
    chk("latched", 16'h0005, st[7:5]);
    ut_run(8'h42);
    off_win(1'h1, 16, 24);
    ut_run(8'h88);
    off_win(1'h1, 3, 5);
    cyc(10);
    chk("retry1", 16'h0001, st[5]);
    ut_run(8'h92);
    off_win(1'h1, 3, 5);
    temp_reading = 16'h0019;
    off_win(1'h0, 14, 26);
    chk("retry_ok", 16'h0000, st[5]);
    $display("ut faults done");
    u_tvfs_host.xfer(1'h1, `TVFS_CMD_VOV_ACTION, 16'h0040, q, a);
    vin_reading = 16'h0042;
    off_win(1'h1, 10, 16);
    vin_reading = 16'h0030;
    clear_faults = 1'h1;
    off_win(1'h0, 1, 6);
    clear_faults = 1'h0;
    u_tvfs_host.xfer(1'h1, `TVFS_CMD_VOV_ACTION, 16'h0088, q, a);
    vin_reading = 16'h0042;
    off_win(1'h1, 3, 5);
    cyc(6);
    chk("vr_early", 16'h0000, st[6]);
    cyc(2);
    chk("vr_latch", 16'h0001, st[6]);
    vin_reading = 16'h0030;
    clear_faults = 1'h1;
    off_win(1'h0, 1, 6);
    chk("vr_clear", 16'h0000, st[6]);
    $display("vin faults done");
    test_done;
  end
endmodule // test_tvfs_supervisor
